// file: pkg/dpm_cfg.svh
// Constants for the dual-ported memory access block
`ifndef DPM_CFG_SVH
`define DPM_CFG_SVH
`define DPM_BLOCK0_BASE 32'h0002_0000
`define DPM_BLOCK1_BASE 32'h0003_0000
`define DPM_NWS_HI 31
`define DPM_NWS_LO 17
`define DPM_NWS_TAG 15'h0001
`define DPM_BLOCK_BIT 16
`define DPM_SEL_EXT 2'h2
`define DPM_DM_PAD 8'h00
`define DPM_ADDR24_PAD 8'h00
`define DPM_BEATS_ONE 2'h1
`define DPM_BEATS_TWO 2'h2
`define DPM_BEATS_THREE 2'h3
`endif

// file: pkg/dpm_pkg.sv
// Types for the dual-ported memory access block
package dpm_pkg;
  typedef enum logic [1:0] {
    DPM_FMT_48,
    DPM_FMT_32,
    DPM_FMT_16
  } dpm_fmt_t;

  typedef enum logic [1:0] {
    DPM_EXT_W16,
    DPM_EXT_W32,
    DPM_EXT_W48
  } dpm_ext_width_t;

  typedef struct packed {
    logic valid;
    logic we;
    dpm_fmt_t fmt;
    logic [31:0] addr;
    logic [39:0] wdata;
  } dpm_dm_req_t;

  typedef struct packed {
    logic valid;
    logic we;
    dpm_fmt_t fmt;
    logic [23:0] addr;
    logic [47:0] wdata;
  } dpm_pm_req_t;

  typedef struct packed {
    logic valid;
    logic we;
    dpm_fmt_t fmt;
    logic [31:0] addr;
    logic [47:0] wdata;
  } dpm_io_req_t;
endpackage

// file: rtl/dpm_access.sv
// Dual-ported internal memory with core conflict logic and external mux
`timescale 1ns/10ps
`default_nettype none
`include "dpm_cfg.svh"

module dpm_access #(
  parameter int WORDS = 4096,
  parameter int CACHE_N = 32
) (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_fetch_valid,
  input wire logic [23:0] i_fetch_addr,
  input wire dpm_pkg::dpm_dm_req_t i_dm,
  input wire logic i_dm_direct,
  input wire logic [31:0] i_dm_imm_addr,
  input wire dpm_pkg::dpm_pm_req_t i_pm,
  input wire dpm_pkg::dpm_io_req_t i_iop,
  input wire dpm_pkg::dpm_ext_width_t i_ext_width,
  output logic o_core_stall,
  output logic o_iop_ready,
  output logic [47:0] o_instr,
  output logic o_instr_valid,
  output logic o_instr_cached,
  output logic [39:0] o_dm_rdata,
  output logic o_dm_rvalid,
  output logic [47:0] o_pm_rdata,
  output logic o_pm_rvalid,
  output logic [47:0] o_iop_rdata,
  output logic o_iop_rvalid,
  output logic o_ext_req,
  output logic o_ext_we,
  output logic [31:0] o_ext_addr,
  output logic [47:0] o_ext_wdata,
  output logic [1:0] o_ext_beats
);
  localparam int AW = $clog2(WORDS);
  localparam int CW = $clog2(CACHE_N);

  typedef enum {ST_RUN, ST_PM_DATA, ST_FETCH} dpm_state_t;

  // Block select: 0, 1, or the external route
  function automatic logic [1:0] blk_of(input logic [31:0] a);
    if (a[`DPM_NWS_HI:`DPM_NWS_LO] == `DPM_NWS_TAG) begin
      blk_of = {1'b0, a[`DPM_BLOCK_BIT]};
    end else begin
      blk_of = `DPM_SEL_EXT;
    end
  endfunction

  // External beats per word for the packer
  function automatic logic [1:0] beats_of(input dpm_pkg::dpm_fmt_t f,
                                          input dpm_pkg::dpm_ext_width_t w);
    if (w == dpm_pkg::DPM_EXT_W48 || f == dpm_pkg::DPM_FMT_16) begin
      beats_of = `DPM_BEATS_ONE;
    end else if (w == dpm_pkg::DPM_EXT_W32) begin
      beats_of = (f == dpm_pkg::DPM_FMT_48) ? `DPM_BEATS_TWO
                                            : `DPM_BEATS_ONE;
    end else begin
      beats_of = (f == dpm_pkg::DPM_FMT_48) ? `DPM_BEATS_THREE
                                            : `DPM_BEATS_TWO;
    end
  endfunction

  // Both blocks; index bit AW picks the block
  logic [47:0] mem [2*WORDS];
  logic [23:0] ctag [CACHE_N];
  logic [47:0] cdata [CACHE_N];
  logic [CACHE_N-1:0] cvalid;
  dpm_state_t state;
  dpm_state_t next_state;

  // Address sources
  wire logic [31:0] dm_addr;
  wire logic [31:0] pm_addr;
  wire logic [31:0] fetch_addr;
  assign dm_addr = i_dm_direct ? i_dm_imm_addr : i_dm.addr;
  assign pm_addr = {`DPM_ADDR24_PAD, i_pm.addr};
  assign fetch_addr = {`DPM_ADDR24_PAD, i_fetch_addr};

  wire logic [1:0] dm_sel;
  wire logic [1:0] pm_sel;
  wire logic [1:0] fetch_sel;
  wire logic [1:0] iop_sel;
  assign dm_sel = blk_of(dm_addr);
  assign pm_sel = blk_of(pm_addr);
  assign fetch_sel = blk_of(fetch_addr);
  assign iop_sel = blk_of(i_iop.addr);

  wire logic dm_ext;
  wire logic pm_ext;
  wire logic fetch_ext;
  wire logic iop_ext;
  assign dm_ext = dm_sel == `DPM_SEL_EXT;
  assign pm_ext = pm_sel == `DPM_SEL_EXT;
  assign fetch_ext = fetch_sel == `DPM_SEL_EXT;
  assign iop_ext = iop_sel == `DPM_SEL_EXT;

  wire logic [AW:0] dm_idx;
  wire logic [AW:0] pm_idx;
  wire logic [AW:0] fetch_idx;
  wire logic [AW:0] iop_idx;
  assign dm_idx = {dm_sel[0], dm_addr[AW-1:0]};
  assign pm_idx = {pm_sel[0], pm_addr[AW-1:0]};
  assign fetch_idx = {fetch_sel[0], fetch_addr[AW-1:0]};
  assign iop_idx = {iop_sel[0], i_iop.addr[AW-1:0]};

  // Instruction cache lookup
  wire logic [CW-1:0] cidx;
  wire logic hit;
  assign cidx = i_fetch_addr[CW-1:0];
  assign hit = cvalid[cidx] && ctag[cidx] == i_fetch_addr;

  // Fetch against program-bus data
  wire logic pm_conf;
  wire logic fetch_via_cache;
  wire logic fetch_miss;
  assign pm_conf = i_fetch_valid && i_pm.valid;
  assign fetch_via_cache = pm_conf && hit;
  assign fetch_miss = pm_conf && !hit;

  // Program-bus owner in the first cycle, data access before fetch
  wire logic [1:0] pm_bus_sel;
  wire logic pm_bus_use;
  assign pm_bus_sel = i_pm.valid ? pm_sel : fetch_sel;
  assign pm_bus_use = i_pm.valid || i_fetch_valid;

  // Same block on the shared core port
  wire logic same_blk;
  assign same_blk = i_dm.valid && pm_bus_use
                    && dm_sel == pm_bus_sel;

  wire logic defer_pm;
  wire logic defer_fetch;
  assign defer_pm = same_blk && i_pm.valid;
  assign defer_fetch = fetch_miss
                       || (same_blk && !i_pm.valid && i_fetch_valid);

  wire logic run;
  wire logic st_pmd;
  wire logic st_fetch;
  assign run = state == ST_RUN;
  assign st_pmd = state == ST_PM_DATA;
  assign st_fetch = state == ST_FETCH;

  always_comb begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (defer_pm) begin
          next_state = ST_PM_DATA;
        end else if (defer_fetch) begin
          next_state = ST_FETCH;
        end
      end
      ST_PM_DATA: begin
        next_state = fetch_miss ? ST_FETCH : ST_RUN;
      end
      ST_FETCH: begin
        next_state = ST_RUN;
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
  end

  // Core holds its requests while stalled
  assign o_core_stall = (run && (defer_pm || defer_fetch))
                        || (st_pmd && fetch_miss);

  // Operations granted this cycle
  wire logic do_dm;
  wire logic do_pm;
  wire logic do_fetch_mem;
  wire logic do_fetch_cache;
  wire logic cache_fill;
  assign do_dm = run && i_dm.valid;
  assign do_pm = i_pm.valid && ((run && !defer_pm) || st_pmd);
  assign do_fetch_mem = i_fetch_valid
                        && ((run && !i_pm.valid && !defer_fetch)
                            || st_fetch);
  assign do_fetch_cache = run && fetch_via_cache;
  assign cache_fill = st_fetch && i_pm.valid && !fetch_ext;

  // External port sharing, core first
  wire logic ext_dm;
  wire logic ext_pm;
  wire logic ext_fetch;
  wire logic core_ext;
  wire logic iop_go;
  wire logic ext_iop;
  assign ext_dm = do_dm && dm_ext;
  assign ext_pm = do_pm && pm_ext;
  assign ext_fetch = do_fetch_mem && fetch_ext;
  assign core_ext = ext_dm || ext_pm || ext_fetch;
  assign o_iop_ready = !(iop_ext && core_ext);
  assign iop_go = i_iop.valid && o_iop_ready;
  assign ext_iop = iop_go && iop_ext;

  wire logic [31:0] next_ext_addr;
  wire logic [47:0] next_ext_wdata;
  wire logic next_ext_we;
  wire dpm_pkg::dpm_fmt_t ext_fmt;
  assign next_ext_addr = ext_dm ? dm_addr
                       : ext_pm ? pm_addr
                       : ext_fetch ? fetch_addr
                       : i_iop.addr;
  assign next_ext_wdata = ext_dm ? {i_dm.wdata, `DPM_DM_PAD}
                        : ext_pm ? i_pm.wdata
                        : i_iop.wdata;
  assign next_ext_we = ext_dm ? i_dm.we
                     : ext_pm ? i_pm.we
                     : !ext_fetch && i_iop.we;
  assign ext_fmt = ext_dm ? i_dm.fmt
                 : ext_pm ? i_pm.fmt
                 : ext_fetch ? dpm_pkg::DPM_FMT_48
                 : i_iop.fmt;

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      state <= ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // Core port and I/O port writes
  always_ff @(posedge i_clock) begin
    if (do_dm && i_dm.we && !dm_ext) begin
      mem[dm_idx] <= {i_dm.wdata, `DPM_DM_PAD};
    end
    if (do_pm && i_pm.we && !pm_ext) begin
      mem[pm_idx] <= i_pm.wdata;
    end
    if (iop_go && i_iop.we && !iop_ext) begin
      mem[iop_idx] <= i_iop.wdata;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      cvalid <= '0;
    end else if (cache_fill) begin
      cvalid[cidx] <= 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (cache_fill) begin
      ctag[cidx] <= i_fetch_addr;
      cdata[cidx] <= mem[fetch_idx];
    end
  end

  // Core read data
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_dm_rvalid <= 1'b0;
      o_dm_rdata <= 40'h00_0000_0000;
      o_pm_rvalid <= 1'b0;
      o_pm_rdata <= 48'h0000_0000_0000;
    end else begin
      o_dm_rvalid <= do_dm && !i_dm.we && !dm_ext;
      if (do_dm && !dm_ext) begin
        o_dm_rdata <= mem[dm_idx][47:8];
      end
      o_pm_rvalid <= do_pm && !i_pm.we && !pm_ext;
      if (do_pm && !pm_ext) begin
        o_pm_rdata <= mem[pm_idx];
      end
    end
  end

  // Instruction delivery from memory or cache
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_instr_valid <= 1'b0;
      o_instr_cached <= 1'b0;
      o_instr <= 48'h0000_0000_0000;
    end else begin
      o_instr_valid <= do_fetch_cache || (do_fetch_mem && !fetch_ext);
      o_instr_cached <= do_fetch_cache;
      if (do_fetch_cache) begin
        o_instr <= cdata[cidx];
      end else if (do_fetch_mem && !fetch_ext) begin
        o_instr <= mem[fetch_idx];
      end
    end
  end

  // I/O port read data
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_iop_rvalid <= 1'b0;
      o_iop_rdata <= 48'h0000_0000_0000;
    end else begin
      o_iop_rvalid <= iop_go && !i_iop.we && !iop_ext;
      if (iop_go && !iop_ext) begin
        o_iop_rdata <= mem[iop_idx];
      end
    end
  end

  // External bus request
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_ext_req <= 1'b0;
      o_ext_we <= 1'b0;
      o_ext_addr <= 32'h0000_0000;
      o_ext_wdata <= 48'h0000_0000_0000;
      o_ext_beats <= 2'h0;
    end else begin
      o_ext_req <= core_ext || ext_iop;
      o_ext_we <= next_ext_we;
      o_ext_addr <= next_ext_addr;
      o_ext_wdata <= next_ext_wdata;
      o_ext_beats <= beats_of(ext_fmt, i_ext_width);
    end
  end
endmodule
`default_nettype wire

// file: dv/dpm_ext_model.sv
// External port partner that records each transfer it is offered
`timescale 1ns/10ps
`default_nettype none
module dpm_ext_model (
  input wire logic i_clock,
  input wire logic i_req,
  input wire logic [31:0] i_addr,
  input wire logic [1:0] i_beats,
  output logic [31:0] o_addr,
  output logic [1:0] o_beats,
  output int o_n
);
  initial o_n = 0;
  always @(posedge i_clock) begin
    if (i_req === 1'b1) begin
      o_addr <= i_addr;
      o_beats <= i_beats;
      o_n <= o_n + 1;
    end
  end
endmodule
`default_nettype wire

// file: dv/dpm_access_monitor.sv
// Port assertions for the dual-ported memory access block
`timescale 1ns/10ps
`default_nettype none
module dpm_access_monitor (
  input wire logic i_clock,
  input wire logic i_reset_n,
  input wire logic i_fetch_valid,
  input wire dpm_pkg::dpm_dm_req_t i_dm,
  input wire logic i_dm_direct,
  input wire dpm_pkg::dpm_pm_req_t i_pm,
  input wire dpm_pkg::dpm_io_req_t i_iop,
  input wire logic o_core_stall,
  input wire logic o_iop_ready,
  input wire logic o_instr_cached,
  input wire logic o_dm_rvalid,
  input wire logic o_pm_rvalid,
  input wire logic o_iop_rvalid,
  input wire logic o_ext_req,
  input wire logic [31:0] o_ext_addr
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  wire dm_ok = i_dm.valid && !i_dm_direct;
  wire dm_in = dm_ok && i_dm.addr[31:17] == 15'h0001;
  wire dm_ex = dm_ok && i_dm.addr[31:17] != 15'h0001;
  wire pm_in = i_pm.valid && i_pm.addr[23:17] == 7'h01;
  wire io_in = i_iop.valid && i_iop.addr[31:17] == 15'h0001;
  wire two = dm_in && pm_in && !i_fetch_valid;
  wire same = two && i_dm.addr[16] == i_pm.addr[16];
  wire diff = two && i_dm.addr[16] != i_pm.addr[16];
  sequence dm_then_pm;
    o_dm_rvalid ##1 o_pm_rvalid;
  endsequence
  stall_same_a: assert property (
    same && !$past(o_core_stall) |-> o_core_stall)
    else $error("no stall on block conflict");
  stall_once_a: assert property (
    same && o_core_stall |=> !o_core_stall)
    else $error("stall longer than one cycle");
  dm_first_a: assert property (same && !i_dm.we && !i_pm.we &&
    !$past(o_core_stall) |=> dm_then_pm) else $error("bus order wrong");
  no_stall_a: assert property (
    diff && !$past(o_core_stall) |-> !o_core_stall)
    else $error("stall across blocks");
  iop_ready_a: assert property (io_in |-> o_iop_ready)
    else $error("io port held off");
  iop_read_a: assert property (io_in && !i_iop.we |=> o_iop_rvalid)
    else $error("io read not answered");
  ext_addr_a: assert property (
    dm_ex && !i_pm.valid && !i_fetch_valid |=>
    o_ext_req && o_ext_addr == $past(i_dm.addr)) else $error("ext addr");
  cache_pm_a: assert property (o_instr_cached |-> $past(i_pm.valid))
    else $error("cache use without bus data");
endmodule
bind dpm_access dpm_access_monitor i_mon (.i_clock, .i_reset_n,
  .i_fetch_valid, .i_dm, .i_dm_direct, .i_pm, .i_iop, .o_core_stall,
  .o_iop_ready, .o_instr_cached, .o_dm_rvalid, .o_pm_rvalid,
  .o_iop_rvalid, .o_ext_req, .o_ext_addr);
`default_nettype wire

// file: dv/testbench.sv
// Self-checking bench for the dual-ported memory access block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic i_clock, i_reset_n, i_fetch_valid, i_dm_direct, cached, b;
  logic o_core_stall, o_iop_ready, o_instr_valid, o_instr_cached;
  logic o_dm_rvalid, o_pm_rvalid, o_iop_rvalid, o_ext_req, o_ext_we;
  logic [23:0] i_fetch_addr;
  logic [31:0] i_dm_imm_addr, o_ext_addr, x_addr, a;
  logic [39:0] o_dm_rdata, d;
  logic [47:0] o_instr, o_pm_rdata, o_iop_rdata, o_ext_wdata, p;
  logic [47:0] dm_got, pm_got, io_got, ins_got, ext_wd;
  logic ext_we;
  logic [1:0] o_ext_beats, x_beats;
  logic [5:0] off;
  dpm_pkg::dpm_dm_req_t i_dm;
  dpm_pkg::dpm_pm_req_t i_pm;
  dpm_pkg::dpm_io_req_t i_iop;
  dpm_pkg::dpm_ext_width_t i_ext_width;
  time dm_t, pm_t;
  int x_n, miscompares, n_compared, nst;
  dpm_access #(.WORDS(64)) i_dut (.i_clock, .i_reset_n, .i_fetch_valid,
    .i_fetch_addr, .i_dm, .i_dm_direct, .i_dm_imm_addr, .i_pm, .i_iop,
    .i_ext_width, .o_core_stall, .o_iop_ready, .o_instr, .o_instr_valid,
    .o_instr_cached, .o_dm_rdata, .o_dm_rvalid, .o_pm_rdata, .o_pm_rvalid,
    .o_iop_rdata, .o_iop_rvalid, .o_ext_req, .o_ext_we, .o_ext_addr,
    .o_ext_wdata, .o_ext_beats);
  dpm_ext_model i_ext (.i_clock, .i_req(o_ext_req), .i_addr(o_ext_addr),
    .i_beats(o_ext_beats), .o_addr(x_addr), .o_beats(x_beats), .o_n(x_n));
  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end
  always @(posedge i_clock) begin
    if (o_dm_rvalid) begin
      dm_got <= {8'h00, o_dm_rdata};
      dm_t <= $time;
    end
    if (o_pm_rvalid) begin
      pm_got <= o_pm_rdata;
      pm_t <= $time;
    end
    if (o_iop_rvalid) io_got <= o_iop_rdata;
    if (o_instr_valid) ins_got <= o_instr;
    if (o_ext_req) begin
      ext_wd <= o_ext_wdata;
      ext_we <= o_ext_we;
    end
    if (o_instr_cached) cached <= 1'b1;
  end
  function automatic dpm_pkg::dpm_dm_req_t mk_dm(logic w, int f,
      logic [31:0] ad, logic [39:0] wd);
    return '{1'b1, w, dpm_pkg::dpm_fmt_t'(f), ad, wd};
  endfunction
  function automatic dpm_pkg::dpm_pm_req_t mk_pm(logic w, logic [23:0] ad,
      logic [47:0] wd);
    return '{1'b1, w, dpm_pkg::DPM_FMT_48, ad, wd};
  endfunction
  function automatic logic [1:0] beats(int f, int w);
    if (f == 0) return 2'(3 - w);
    if (f == 1 && w == 0) return 2'h2;
    return 2'h1;
  endfunction
  task automatic chk(input logic [47:0] g, input logic [47:0] e,
      input string m);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic go(input dpm_pkg::dpm_dm_req_t dq,
      input dpm_pkg::dpm_pm_req_t pq, input logic fv,
      input dpm_pkg::dpm_io_req_t io);
    @(posedge i_clock);
    i_dm <= dq;
    i_pm <= pq;
    i_fetch_valid <= fv;
    i_iop <= io;
    nst = 0;
    #1;
    while (o_core_stall === 1'b1 && nst < 4) begin
      @(posedge i_clock);
      #1;
      nst++;
    end
    @(posedge i_clock);
    i_dm <= '0;
    i_pm <= '0;
    i_fetch_valid <= 1'b0;
    i_iop <= '0;
    repeat (3) @(posedge i_clock);
  endtask
  task automatic conclude;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    conclude();
  end
  initial begin
    {i_reset_n, i_fetch_valid, i_dm_direct, cached} = '0;
    {i_fetch_addr, i_dm_imm_addr, i_dm, i_pm, i_iop} = '0;
    i_ext_width = dpm_pkg::DPM_EXT_W48;
    void'($urandom(14));
    repeat (4) @(posedge i_clock);
    i_reset_n <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      off = 6'($urandom);
      b = 1'($urandom);
      d = 40'({$urandom, $urandom});
      p = 48'({$urandom, $urandom});
      go(mk_dm(1, 1, {15'h0001, b, 10'h0, off}, d),
        mk_pm(1, {7'h01, !b, 10'h0, off}, p), 0, '0);
      chk(48'(nst), 48'h0, "dual write stall");
      go(mk_dm(0, 1, {15'h0001, !b, 10'h0, off}, '0),
        mk_pm(0, {7'h01, b, 10'h0, off}, '0), 0,
        '{1'b1, 1'b0, dpm_pkg::DPM_FMT_48, {15'h0001, b, 10'h0, off}, '0});
      chk(48'(nst), 48'h0, "io beside core stall");
      chk(dm_got, {8'h00, p[47:8]}, "data bus read");
      chk(pm_got, {d, 8'h00}, "program bus read");
      chk(io_got, {d, 8'h00}, "io read");
      go(mk_dm(0, 1, {15'h0001, b, 10'h0, off}, '0),
        mk_pm(0, {7'h01, b, 10'h0, off}, '0), 0, '0);
      chk(48'(nst), 48'h1, "block conflict stall");
      chk(48'(dm_t < pm_t), 48'h1, "data bus first");
      chk(dm_got, {8'h00, d}, "upper bits of data bus");
    end
    i_fetch_addr <= 24'h020040;
    p = 48'({$urandom, $urandom});
    go('0, mk_pm(1, 24'h020040, p), 0, '0);
    for (int k = 0; k < 2; k++) begin
      cached <= 1'b0;
      ins_got <= '0;
      go('0, mk_pm(0, 24'h030000, '0), 1, '0);
      chk(48'(nst), 48'(k == 0), "fetch miss stall");
      chk(48'(cached), 48'(k == 1), "fetch from cache");
      chk(ins_got, p, "fetched word");
    end
    for (int f = 0; f < 3; f++) begin
      for (int w = 0; w < 3; w++) begin
        i_ext_width <= dpm_pkg::dpm_ext_width_t'(w);
        a = {24'h004000, 8'($urandom)};
        d = 40'({$urandom, $urandom});
        go(mk_dm(1, f, a, d), '0, 0, '0);
        chk(48'(x_addr), 48'(a), "ext addr");
        chk(ext_wd, {d, 8'h00}, "ext write data");
        chk(48'(ext_we), 48'h1, "ext write strobe");
        chk(48'(x_beats), 48'(beats(f, w)), "ext beats");
      end
    end
    i_dm_direct <= 1'b1;
    i_dm_imm_addr <= 32'h00501234;
    go(mk_dm(0, 1, 32'h00020000, '0), '0, 0, '0);
    chk(48'(x_addr), 48'h501234, "direct addr");
    chk(48'(x_n), 48'hA, "ext transfer count");
    conclude();
  end
endmodule
`default_nettype wire
